// ==== include/pt1_pkg.sv ====
// Purpose: Shared constants and types of the PT1 smoothing filter.
// Assumes: A 40 MHz system clock and a 32-bit AXI4-Lite register port.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package pt1_pkg;
  // Clock and time base.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CLKS_PER_MS = CLK_HZ / MS_PER_S;
  // Recovery time resolution is 0.1 s, so one unit is 100 ms.
  localparam int unsigned TG_UNIT_MS = 100;
  // Recovery times up to this many units use the short scan period.
  localparam int unsigned TG_SHORT = 10;
  localparam int unsigned TA_SHORT_MS = 10;
  // Longer recovery times scan at one hundredth of the recovery time.
  localparam int unsigned TA_DIV = 100;
  // Gain is in percent: this value is unity.
  localparam int unsigned GAIN_UNITY = 100;
  // Register byte offsets.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RECOV = 8'h04;
  localparam logic [7:0] OFF_GAIN = 8'h08;
  localparam logic [7:0] OFF_CYCLE = 8'h0c;
  localparam logic [7:0] OFF_INPUT = 8'h10;
  localparam logic [7:0] OFF_OUTPUT = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_CARRY_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int IRQ_SCAN_BIT = 0;
  localparam int IRQ_CARRY_BIT = 1;
  localparam int IRQ_W = 2;
  // Reset values.
  localparam logic [15:0] RST_RECOV = 16'h000a;
  localparam logic [15:0] RST_GAIN = 16'h0064;
  localparam logic [15:0] RST_CYCLE = 16'h0001;
  // Output range limits.
  localparam logic signed [15:0] Y_MAX = 16'sh7fff;
  localparam logic signed [15:0] Y_MIN = -16'sh8000;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Evaluation sequencer states.
  typedef enum logic [3:0] {
    PT1_IDLE = 4'b0001,
    PT1_START = 4'b0010,
    PT1_DIV = 4'b0100,
    PT1_UPD = 4'b1000
  } pt1_state_e;
endpackage : pt1_pkg

// ==== verilog/pt1_tick_gen.sv ====
// Purpose: Millisecond base and device cycle tick for the filter.
// Assumes: One system clock; cycle length in whole milliseconds.
// Notes: A cycle length of zero is run as one millisecond.
`timescale 1ns/1ps
`default_nettype none
module pt1_tick_gen #(
  parameter int unsigned CLKS_PER_MS = pt1_pkg::CLKS_PER_MS
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Cycle length in ms and the resulting tick.
  input wire logic [15:0] cycle_ms,
  output logic cycle_tick
);
  import pt1_pkg::*;
  localparam int CW = $clog2(CLKS_PER_MS + 1);
  localparam logic [CW-1:0] CLK_LAST = CW'(CLKS_PER_MS - 1);
  logic [CW-1:0] clk_cnt_q;
  logic [15:0] ms_cnt_q;
  logic cycle_tick_q;
  logic ms_tick;
  logic [15:0] cyc_len;

  // Millisecond prescaler: one enable pulse per millisecond.
  assign ms_tick = (clk_cnt_q == CLK_LAST);
  assign cyc_len = (cycle_ms == 16'h0000) ? 16'h0001 : cycle_ms;
  assign cycle_tick = cycle_tick_q;

  // Free running clock counter.
  always_ff @(posedge ref_clk) begin
    if (!nrst || ms_tick) begin
      clk_cnt_q <= '0;
    end else begin
      clk_cnt_q <= clk_cnt_q + CW'(1);
    end
  end

  // Counts milliseconds into device cycles; a count already past a shortened length ends the cycle at the next millisecond.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ms_cnt_q <= 16'h0000;
      cycle_tick_q <= 1'b0;
    end else begin
      cycle_tick_q <= 1'b0;
      if (ms_tick) begin
        if (ms_cnt_q + 16'h0001 >= cyc_len) begin
          ms_cnt_q <= 16'h0000;
          cycle_tick_q <= 1'b1;
        end else begin
          ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule : pt1_tick_gen
`default_nettype wire

// ==== verilog/pt1_div.sv ====
// Purpose: Serial restoring unsigned divider, one quotient bit per clock.
// Assumes: Divisor is never zero while a division runs.
// Notes: Clear aborts a running division without a done pulse.
`timescale 1ns/1ps
`default_nettype none
module pt1_div #(
  parameter int NW = 64,
  parameter int DW = 32
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clear,
  // Operands and start.
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  // Result.
  output logic busy,
  output logic done,
  output logic [NW-1:0] quo
);
  localparam int CW = $clog2(NW + 1);
  logic [DW:0] rem_q;
  logic [NW-1:0] quo_q;
  logic [CW-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic [DW:0] trial;
  logic ge;

  assign trial = {rem_q[DW-1:0], quo_q[NW-1]};
  assign ge = (trial >= {1'b0, den});
  assign busy = busy_q;
  assign done = done_q;
  assign quo = quo_q;

  // Shift-subtract loop; the divisor is held steady by the caller.
  always_ff @(posedge ref_clk) begin
    if (!nrst || clear) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        quo_q <= num;
        rem_q <= '0;
        cnt_q <= CW'(NW);
      end else if (busy_q) begin
        quo_q <= {quo_q[NW-2:0], ge};
        rem_q <= ge ? (trial - {1'b0, den}) : trial;
        cnt_q <= cnt_q - CW'(1);
        if (cnt_q == CW'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : pt1_div
`default_nettype wire

// ==== verilog/pt1_filter.sv ====
// Purpose: First-order low-pass smoothing filter with an AXI4-Lite port.
// Assumes: Software writes samples and settings; one 40 MHz clock.
// Notes: Each scan runs a 64-cycle division, far shorter than a cycle.
// How it works
// - Enable high runs the filter; enable low holds reset with output zero.
// - Each input sample is multiplied by the gain factor before smoothing.
// - Gain is unsigned percent; 100 is unity, 50 is one half.
// - Recovery time counts in 0.1 s units, 0 to 65535.
// - First evaluation after start or reset loads the output with the input.
// - Scan period is 10 ms up to 1000 ms, else recovery time over 100.
// - Term is scan over recovery time times gain-scaled input minus output.
// - Effective scan period is a whole number of device cycles.
// - Carry flag is set while the output leaves -32768 to +32767.
// - Step response is exponential, near 0.63 after one recovery time.
`timescale 1ns/1ps
`default_nettype none
module pt1_filter #(
  parameter int unsigned CLKS_PER_MS = pt1_pkg::CLKS_PER_MS
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // AXI4-Lite write address.
  input wire logic [pt1_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [pt1_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt.
  output logic irq
);
  import pt1_pkg::*;

  // Bus state.
  logic aw_got_q;
  logic w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic do_write;
  logic wr_known;
  logic rd_known;
  logic [31:0] rd_word;
  // Settings and sample.
  logic en_q;
  logic [15:0] recov_q;
  logic [15:0] gain_q;
  logic [15:0] cycle_q;
  logic signed [15:0] in_q;
  // Filter state.
  pt1_state_e state_q;
  logic signed [15:0] y_q;
  logic carry_q;
  logic first_q;
  logic [31:0] elapsed_q;
  logic neg_q;
  logic [63:0] num_q;
  logic [31:0] den_q;
  // Interrupt state.
  logic [IRQ_W-1:0] sticky_q;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] evt;
  logic scan_evt;
  logic carry_evt;
  // Arithmetic.
  logic cycle_tick;
  logic [31:0] tg_ms;
  logic [31:0] ta_ms;
  logic [31:0] ta_eff;
  logic [31:0] tg_eff;
  logic [31:0] cyc_ms;
  logic scan_due;
  logic signed [33:0] gain_x;
  logic signed [33:0] diff_w;
  logic [33:0] diff_mag;
  logic div_busy;
  logic div_done;
  logic [63:0] quo;
  logic signed [35:0] step_w;
  logic signed [35:0] sum_w;

  // Merges the enabled low byte lanes into a 16-bit setting.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] ws);
    logic [15:0] r;
    r = old;
    if (ws[0]) r[7:0] = wd[7:0];
    if (ws[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge16

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign do_write = aw_got_q && w_got_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Only the register words below are writable; the rest answer SLVERR.
  always_comb begin
    case (awaddr_q)
      OFF_CTRL, OFF_RECOV, OFF_GAIN, OFF_CYCLE, OFF_INPUT,
      OFF_IRQ_STAT, OFF_IRQ_MASK: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  // Captures write address and data and produces the response.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read mux; unused upper bits read as zero, except input and output, which read sign-extended.
  always_comb begin
    rd_known = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      OFF_CTRL: rd_word[CTRL_EN_BIT] = en_q;
      OFF_RECOV: rd_word[15:0] = recov_q;
      OFF_GAIN: rd_word[15:0] = gain_q;
      OFF_CYCLE: rd_word[15:0] = cycle_q;
      OFF_INPUT: rd_word = 32'(in_q);
      OFF_OUTPUT: rd_word = 32'(y_q);
      OFF_STATUS: begin
        rd_word[ST_CARRY_BIT] = carry_q;
        rd_word[ST_RUN_BIT] = !state_q[0] || div_busy;
      end
      OFF_IRQ_STAT: rd_word[IRQ_W-1:0] = sticky_q;
      OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = mask_q;
      default: rd_known = 1'b0;
    endcase
  end

  // Read channel: data registered on the address handshake.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_known ? rd_word : 32'h0000_0000;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Settings written by software.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      en_q <= 1'b0;
      recov_q <= RST_RECOV;
      gain_q <= RST_GAIN;
      cycle_q <= RST_CYCLE;
      in_q <= 16'sh0000;
      mask_q <= '0;
    end else if (do_write) begin
      case (awaddr_q)
        OFF_CTRL: if (wstrb_q[0]) en_q <= wdata_q[CTRL_EN_BIT];
        OFF_RECOV: recov_q <= merge16(recov_q, wdata_q, wstrb_q);
        OFF_GAIN: gain_q <= merge16(gain_q, wdata_q, wstrb_q);
        OFF_CYCLE: cycle_q <= merge16(cycle_q, wdata_q, wstrb_q);
        OFF_INPUT: in_q <= merge16(in_q, wdata_q, wstrb_q);
        OFF_IRQ_MASK: if (wstrb_q[0]) mask_q <= wdata_q[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Device cycle tick: the filter is only evaluated on these.
  pt1_tick_gen #(
    .CLKS_PER_MS(CLKS_PER_MS)
  ) u_tick (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cycle_ms(cycle_q),
    .cycle_tick(cycle_tick)
  );

  // Scan period from the recovery time, both in ms.
  assign tg_ms = 32'(recov_q) * 32'(TG_UNIT_MS);
  assign ta_ms = (32'(recov_q) <= 32'(TG_SHORT)) ? 32'(TA_SHORT_MS)
               : tg_ms / 32'(TA_DIV);
  assign scan_due = (elapsed_q >= ta_ms);
  // A zero recovery time runs as a ratio of one, passing the scaled input.
  assign tg_eff = (tg_ms == 32'h0000_0000) ? 32'h0000_0001 : tg_ms;
  // Clamping the ratio to one keeps an overlong scan from overshooting.
  assign ta_eff = (elapsed_q > tg_eff) ? tg_eff : elapsed_q;

  // A zero cycle length ticks as 1 ms, so it must also count as 1 ms here.
  assign cyc_ms = (cycle_q == 16'h0000) ? 32'h0000_0001 : 32'(cycle_q);

  // Elapsed time grows by whole device cycles only; the loading tick opens the first scan.
  always_ff @(posedge ref_clk) begin
    if (!nrst || !en_q) begin
      elapsed_q <= 32'h0000_0000;
    end else if (state_q == PT1_IDLE && !first_q && scan_due) begin
      elapsed_q <= cycle_tick ? cyc_ms : 32'h0000_0000;
    end else if (cycle_tick && !first_q) begin
      elapsed_q <= elapsed_q + cyc_ms;
    end
  end

  // Gain-scaled input minus the previous output, both in percent units.
  assign gain_x = $signed({1'b0, gain_q}) * in_q;
  assign diff_w = gain_x - $signed(34'(GAIN_UNITY)) * 34'(y_q);
  assign diff_mag = diff_w[33] ? 34'(-diff_w) : 34'(diff_w);

  pt1_div #(
    .NW(64),
    .DW(32)
  ) u_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clear(!en_q),
    .start(state_q == PT1_START),
    .num(num_q),
    .den(den_q),
    .busy(div_busy),
    .done(div_done),
    .quo(quo)
  );

  // Increment and the unsaturated sum; PT1_UPD saturates it.
  always_comb begin
    step_w = $signed({1'b0, quo[34:0]});
    if (neg_q) begin
      step_w = -step_w;
    end
    sum_w = 36'(y_q) + step_w;
  end

  // Evaluation sequencer and filter state.
  always_ff @(posedge ref_clk) begin
    if (!nrst || !en_q) begin
      state_q <= PT1_IDLE;
      y_q <= 16'sh0000;
      carry_q <= 1'b0;
      first_q <= 1'b1;
      neg_q <= 1'b0;
      num_q <= 64'h0;
      den_q <= 32'h0000_0001;
    end else begin
      case (state_q)
        PT1_IDLE: begin
          if (first_q && cycle_tick) begin
            y_q <= in_q;
            carry_q <= 1'b0;
            first_q <= 1'b0;
          end else if (!first_q && scan_due) begin
            // Ratio ta/tg times gain/100 becomes one product over one divisor.
            num_q <= 64'(diff_mag) * 64'(ta_eff);
            den_q <= 32'(GAIN_UNITY) * tg_eff;
            neg_q <= diff_w[33];
            state_q <= PT1_START;
          end
        end
        PT1_START: state_q <= PT1_DIV;
        PT1_DIV: if (div_done) state_q <= PT1_UPD;
        PT1_UPD: begin
          // Repeated fractional steps give the exponential approach.
          if (sum_w > 36'(Y_MAX)) begin
            y_q <= Y_MAX;
            carry_q <= 1'b1;
          end else if (sum_w < 36'(Y_MIN)) begin
            y_q <= Y_MIN;
            carry_q <= 1'b1;
          end else begin
            y_q <= 16'(sum_w);
            carry_q <= 1'b0;
          end
          state_q <= PT1_IDLE;
        end
        default: state_q <= PT1_IDLE;
      endcase
    end
  end

  // Events: each finished evaluation, and carry becoming set.
  assign scan_evt = (state_q == PT1_UPD) || (state_q == PT1_IDLE && en_q
                    && first_q && cycle_tick);
  assign carry_evt = (state_q == PT1_UPD) && !carry_q
                   && ((sum_w > 36'(Y_MAX)) || (sum_w < 36'(Y_MIN)));
  always_comb begin
    evt = '0;
    evt[IRQ_SCAN_BIT] = scan_evt;
    evt[IRQ_CARRY_BIT] = carry_evt;
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sticky_q <= '0;
    end else if (do_write && awaddr_q == OFF_IRQ_STAT && wstrb_q[0]) begin
      sticky_q <= (sticky_q & ~wdata_q[IRQ_W-1:0]) | evt;
    end else begin
      sticky_q <= sticky_q | evt;
    end
  end

  assign irq = |(sticky_q & mask_q);
endmodule : pt1_filter
`default_nettype wire

// ==== bench/pt1_filter_monitor.sv ====
// Purpose: Port checks on the bus handshakes and filter output reads.
// Assumes: The master offers write address and write data together.
// Notes: Bound to every filter instance; only whole-pair writes are timed.
`timescale 1ns/1ps
`default_nettype none
module pt1_filter_mon (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Write channels.
  input wire logic [pt1_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic [pt1_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pt1_pkg::*;
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic wr_go;
  logic rd_go;
  // Handshake shorthands shared by the properties below.
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("write response late or missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (rd_go |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late or missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_out_range: assert property (
    rd_go && s_axi_araddr == OFF_OUTPUT |=> s_axi_rresp == RESP_OKAY
      && s_axi_rdata[31:16] == {16{s_axi_rdata[15]}})
    else $error("output read outside signed 16-bit range");
  a_unmapped_read: assert property (
    rd_go && s_axi_araddr > OFF_IRQ_MASK |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_ro_write: assert property (wr_go && s_axi_awaddr == OFF_OUTPUT |-> ##2 s_axi_bresp == RESP_SLVERR)
    else $error("write to output not refused");
endmodule : pt1_filter_mon
bind pt1_filter pt1_filter_mon i_pt1_filter_mon (
  .ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ==== bench/pt1_user_model.sv ====
// Purpose: User program model that sets the filter up over AXI4-Lite.
// Assumes: One write and one read at most under way at a time.
// Notes: Released payloads show their inverse so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module pt1_user_model (
  // Clock.
  input wire logic ref_clk,
  // Write channels.
  output logic [pt1_pkg::ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels.
  output logic [pt1_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  import pt1_pkg::*;
  // Quiet bus from time zero.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Write: both halves offered at once, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    // Ready comes late so that a response held against low ready is exercised.
    repeat (2) @(posedge ref_clk);
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Read: address held until taken, data taken at the rvalid edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    // One edge with low ready lets read data be seen holding.
    @(posedge ref_clk);
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : pt1_user_model
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the smoothing filter.
// Assumes: A shortened millisecond of 100 clocks and a 1 ms device cycle, 3 ms in the last test.
// Notes: Waits end clear of load and scan times by a margin, so tick phase does not matter.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pt1_pkg::*;
  localparam int unsigned CPM = 100;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  int err_total = 0;
  int checked = 0;
  logic [7:0] ra [9] = '{OFF_CTRL, OFF_RECOV, OFF_GAIN, OFF_CYCLE, OFF_INPUT, OFF_OUTPUT,
                         OFF_STATUS, OFF_IRQ_STAT, OFF_IRQ_MASK};
  logic [31:0] rv [9] = '{32'h0, {16'h0, RST_RECOV}, {16'h0, RST_GAIN}, {16'h0, RST_CYCLE},
                          32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  // Half period of 12.5 ns gives 40 MHz.
  always #12.5 ref_clk = ~ref_clk;
  pt1_filter #(.CLKS_PER_MS(CPM)) i_pt1_filter (
    .ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq
  );
  pt1_user_model i_pt1_user_model (
    .ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_pt1_user_model.wr(a, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask : w
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_pt1_user_model.rd(a, d, r);
    chk({30'h0, r}, {30'h0, er});
    chk(d & msk, exp);
  endtask : rc
  // Waits n clocks; 12 ms covers one 10 ms scan plus margin for tick phase and the division.
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic end_sim();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // Main sequence; the device cycle is 1 ms, a tenth of the 10 ms scan, until the last test sets 3 ms.
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rc(ra[i], rv[i], 32'hffffffff, RESP_OKAY);
    end
    rc(8'h24, 32'h0, 32'hffffffff, RESP_SLVERR);
    w(OFF_OUTPUT, 32'h1234, RESP_SLVERR);
    w(OFF_INPUT, 32'h3e8, RESP_OKAY);
    w(OFF_CTRL, 32'h1, RESP_OKAY);
    idle(3 * CPM);
    rc(OFF_OUTPUT, 32'h3e8, 32'hffffffff, RESP_OKAY);
    w(OFF_INPUT, 32'h7d0, RESP_OKAY);
    idle(12 * CPM);
    rc(OFF_OUTPUT, 32'h3f2, 32'hffffffff, RESP_OKAY);
    w(OFF_RECOV, 32'h0, RESP_OKAY);
    w(OFF_GAIN, 32'h32, RESP_OKAY);
    idle(12 * CPM);
    rc(OFF_OUTPUT, 32'h3e8, 32'hffffffff, RESP_OKAY);
    w(OFF_GAIN, 32'hc8, RESP_OKAY);
    w(OFF_INPUT, 32'h7530, RESP_OKAY);
    w(OFF_IRQ_MASK, 32'h2, RESP_OKAY);
    idle(12 * CPM);
    rc(OFF_OUTPUT, 32'h7fff, 32'hffffffff, RESP_OKAY);
    rc(OFF_STATUS, 32'h1, 32'h1, RESP_OKAY);
    chk_bit(irq, 1'b1);
    w(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
    chk_bit(irq, 1'b0);
    w(OFF_INPUT, 32'h8ad0, RESP_OKAY);
    idle(12 * CPM);
    rc(OFF_OUTPUT, 32'hffff8000, 32'hffffffff, RESP_OKAY);
    w(OFF_CTRL, 32'h0, RESP_OKAY);
    rc(OFF_OUTPUT, 32'h0, 32'hffffffff, RESP_OKAY);
    rc(OFF_STATUS, 32'h0, 32'h1, RESP_OKAY);
    // A 2 s recovery time must stretch the scan to 20 ms.
    w(OFF_RECOV, 32'h14, RESP_OKAY);
    w(OFF_GAIN, 32'h64, RESP_OKAY);
    w(OFF_INPUT, 32'h3e8, RESP_OKAY);
    w(OFF_CTRL, 32'h1, RESP_OKAY);
    idle(3 * CPM);
    rc(OFF_OUTPUT, 32'h3e8, 32'hffffffff, RESP_OKAY);
    w(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
    idle(12 * CPM);
    rc(OFF_IRQ_STAT, 32'h0, 32'h1, RESP_OKAY);
    idle(12 * CPM);
    rc(OFF_IRQ_STAT, 32'h1, 32'h1, RESP_OKAY);
    // A 3 ms cycle stretches the 10 ms scan to 12 ms, so one step adds 12.
    w(OFF_CTRL, 32'h0, RESP_OKAY);
    w(OFF_CYCLE, 32'h3, RESP_OKAY);
    w(OFF_RECOV, 32'ha, RESP_OKAY);
    w(OFF_CTRL, 32'h1, RESP_OKAY);
    idle(4 * CPM);
    w(OFF_INPUT, 32'h7d0, RESP_OKAY);
    idle(15 * CPM);
    rc(OFF_OUTPUT, 32'h3f4, 32'hffffffff, RESP_OKAY);
    end_sim();
  end
  // Watchdog: the tests need about 10000 cycles.
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
